// file: verilog/lars_pkg.sv
package lars_pkg;

  // pixel counts per array arrangement
  localparam int PIXELS_SECTION = 384;  // one section read alone
  localparam int PIXELS_CASCADE = 768;  // both sections in series

  // integrator reset sequencing, counted in sensor clocks
  localparam int SETUP_CLOCKS   = 18;   // clocks with integrators held in reset
  localparam int RELEASE_CLOCK  = 19;   // clock whose rising edge starts integration

  // word widths of the digital pixel model
  localparam int PIX_W          = 12;   // pixel value width
  localparam int FIFO_DEPTH     = 4;    // words buffered toward the converter side
  localparam int SYNC_STAGES    = 2;    // flip-flops on every pin input
  localparam int GAP_W          = 8;    // width of the clock spacing counter

  // timing: fastest legal sensor clock against the system clock
  localparam int MCLK_PERIOD_NS     = 4;    // 250 MHz system clock
  localparam int MIN_SENS_PERIOD_NS = 125;  // 8 MHz sensor clock limit
  localparam int MIN_SENS_PERIOD_CYC =
    (MIN_SENS_PERIOD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;  // least time, rounded up

  // reset values
  localparam logic [PIX_W-1:0] PIX_RESET = 12'h000;  // empty integrator / sample

  // readout sequencer states
  typedef enum logic [2:0] {
    LARS_IDLE  = 3'b001,  // output floating, all pixels sampling
    LARS_SETUP = 3'b010,  // integrators in reset, first pixels shifting out
    LARS_READ  = 3'b100   // integrating, remaining pixels shifting out
  } lars_state_t;

endpackage

// file: verilog/lars_sync.sv
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// two flip-flop level synchroniser for pin inputs
module lars_sync #(
  parameter int WIDTH = 1  // number of independent levels
) (
  input  wire logic             mclk,   // system clock
  input  wire logic             rst,    // asynchronous reset, active high
  input  wire logic [WIDTH-1:0] din,    // asynchronous levels
  output logic      [WIDTH-1:0] dout    // levels in the mclk domain
);

  logic [WIDTH-1:0] meta_q;   // first stage, read only by the second stage
  logic [WIDTH-1:0] sync_q;   // second stage

  // both stages clear to low so idle pins read as inactive
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;

endmodule // lars_sync

// file: verilog/lars_fifo.sv
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// small synchronous fifo with valid/ready on both sides
module lars_fifo #(
  parameter int WIDTH = 8,  // word width
  parameter int DEPTH = 4   // number of words
) (
  input  wire logic             mclk,       // system clock
  input  wire logic             rst,        // asynchronous reset, active high
  input  wire logic             in_valid,   // write request
  output logic                  in_ready,   // space available
  input  wire logic [WIDTH-1:0] in_data,    // write word
  output logic                  out_valid,  // word available
  input  wire logic             out_ready,  // reader takes the word
  output logic      [WIDTH-1:0] out_data    // head word
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0]   FULL_C = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  // handshake flags come straight from the fill count
  assign in_ready  = (cnt_q != FULL_C);
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointer wrap handles depths that are not a power of two
  always_comb begin
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) wr_d = (wr_q == LAST_C) ? '0 : wr_q + 1'b1;
    if (pop)  rd_d = (rd_q == LAST_C) ? '0 : rd_q + 1'b1;
    if (push && !pop) cnt_d = cnt_q + 1'b1;
    else if (pop && !push) cnt_d = cnt_q - 1'b1;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage needs no reset; unread words are never presented
  always_ff @(posedge mclk) begin
    if (push) mem_q[wr_q] <= in_data;
  end

endmodule // lars_fifo

// file: verilog/lars_top.sv
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - start pulse seen high at a clock rise restarts readout and integration setup
// - integration equals start-to-hold interval less the 18 setup clocks
// - all pixels held together at start; pixel 1 out, one more each clock
// - integrators reset through start plus 17 clocks, released at clock 19
// - pixels 1-18 resume sampling at clock 19; pixel k resumes at clock k+1
// - at clock n+1 last pixel resumes sampling and output floats
// - frame integrated in one period is shifted out during the next
// - each pixel stands a whole clock period; clock at most 8 MHz
module lars_top #(
  parameter int N = lars_pkg::PIXELS_CASCADE  // pixels in the readout chain
) (
  input  wire logic                      mclk,                     // system clock, 250 MHz
  input  wire logic                      rst,                      // asynchronous reset, active high
  input  wire logic                      sens_clk_pin,             // sensor clock from controller
  input  wire logic                      start_pin,                // start-integration pulse
  input  wire logic                      hold_pin,                 // hold pulse, usually tied to start
  input  wire logic [lars_pkg::PIX_W-1:0] light_level,             // illumination, added each mclk
  output logic      [lars_pkg::PIX_W-1:0] pixel_analog_out,        // value of the pixel on the output
  output logic                           pixel_out_en,             // output driven; low means floating
  output logic                           integrator_reset_switch,  // integrators held at zero
  output logic      [$clog2(N+2)-1:0]    sample_select_switch,     // pixel on the output, 0 when none
  output logic      [31:0]               integ_period,             // last integration length in mclk
  output logic                           stream_valid,             // buffered pixel available
  input  wire logic                      stream_ready,             // converter side takes a pixel
  output logic      [lars_pkg::PIX_W-1:0] stream_data,             // buffered pixel value
  output logic      [$clog2(N+2)-1:0]    stream_index,             // buffered pixel number, from 1
  output logic                           fifo_in_ready,            // buffer can take the next pixel
  output logic                           fifo_overrun,             // a pixel was dropped, held until the next start
  output logic                           clk_overspeed             // sensor clock too fast, sticky
);

  localparam int CW = $clog2(N+2);
  localparam int PW = lars_pkg::PIX_W;
  localparam logic [CW-1:0] N_C     = CW'(N);
  localparam logic [CW-1:0] SETUP_C = CW'(lars_pkg::SETUP_CLOCKS);
  localparam logic [CW-1:0] REL_C   = CW'(lars_pkg::RELEASE_CLOCK);
  localparam logic [CW-1:0] ONE_C   = {{(CW-1){1'b0}}, 1'b1};
  localparam logic [lars_pkg::GAP_W-1:0] MIN_GAP_C = lars_pkg::GAP_W'(lars_pkg::MIN_SENS_PERIOD_CYC);

  //////////////////////////////////////////////////////////////////////////////
  // pin inputs cross into mclk through two flip-flops

  logic sclk_s, start_s, hold_s;
  logic sclk_prev_q;
  logic clk_rise;

  lars_sync #(
    .WIDTH (3)
  ) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .din  ({sens_clk_pin, start_pin, hold_pin}),
    .dout ({sclk_s, start_s, hold_s})
  );

  // edge detect works on the synchronised copy only
  assign clk_rise = sclk_s && !sclk_prev_q;

  //////////////////////////////////////////////////////////////////////////////
  // readout sequencer

  lars_pkg::lars_state_t state_q, state_d;
  logic [CW-1:0]         cnt_q, cnt_d;      // sensor clock number since start, 1 = start clock
  logic [N-1:0]          samp_q, samp_d;    // pixel sampling capacitor tracks integrator
  logic [N-1:0]          stale_q, stale_d;  // pixel was not sampling at the last hold
  logic [PW-1:0]         snap_q, snap_d;    // integrator value captured at the last hold
  logic [PW-1:0]         old_q, old_d;      // value captured at the hold before that
  logic [PW-1:0]         integ_q, integ_d;  // common integrating capacitor
  logic                  start_hit, hold_hit;

  assign start_hit = clk_rise && start_s;  // start is only honoured at a clock rise
  assign hold_hit  = clk_rise && hold_s;

  // one counter walks both the reset window and the pixel output
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    if (start_hit) begin
      state_d = lars_pkg::LARS_SETUP;
      cnt_d   = ONE_C;
    end else if (clk_rise) begin
      case (state_q)
        lars_pkg::LARS_SETUP: begin
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == SETUP_C) state_d = lars_pkg::LARS_READ;
        end
        lars_pkg::LARS_READ: begin
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == N_C) begin
            state_d = lars_pkg::LARS_IDLE;
            cnt_d   = '0;
          end
        end
        lars_pkg::LARS_IDLE: begin
          cnt_d = '0;
        end
        default: begin
          state_d = lars_pkg::LARS_IDLE;
          cnt_d   = '0;
        end
      endcase
    end
  end

  // hold freezes every sampling capacitor at once; pixels rejoin after their turn
  always_comb begin
    samp_d  = samp_q;
    stale_d = stale_q;
    snap_d  = snap_q;
    old_d   = old_q;
    if (hold_hit) begin
      samp_d  = '0;
      stale_d = ~samp_q;  // a pixel still waiting keeps the older sample
      snap_d  = integ_q;
      old_d   = snap_q;
    end else if (clk_rise) begin
      if (state_q == lars_pkg::LARS_SETUP && cnt_q == SETUP_C && !start_s) begin
        samp_d[lars_pkg::SETUP_CLOCKS-1:0] = '1;
      end else if (state_q == lars_pkg::LARS_READ && cnt_q >= REL_C && !start_s) begin
        samp_d[cnt_q - 1'b1] = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sclk_prev_q <= 1'b0;
      state_q     <= lars_pkg::LARS_IDLE;
      cnt_q       <= '0;
      samp_q      <= '1;
      stale_q     <= '0;
      snap_q      <= lars_pkg::PIX_RESET;
      old_q       <= lars_pkg::PIX_RESET;
    end else begin
      sclk_prev_q <= sclk_s;
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      samp_q      <= samp_d;
      stale_q     <= stale_d;
      snap_q      <= snap_d;
      old_q       <= old_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // integrating capacitor and integration length

  logic [31:0]   period_q, period_d;  // mclk cycles integrated since release
  logic [31:0]   iper_q, iper_d;
  logic [PW:0]   integ_sum;

  assign integ_sum = {1'b0, integ_q} + {1'b0, light_level};
  assign integrator_reset_switch = (state_q == lars_pkg::LARS_SETUP);

  // charge saturates instead of wrapping, like a full capacitor
  always_comb begin
    integ_d  = integ_sum[PW] ? '1 : integ_sum[PW-1:0];
    period_d = (period_q == 32'hFFFFFFFF) ? period_q : period_q + 32'h00000001;
    iper_d   = iper_q;
    if (integrator_reset_switch) begin
      integ_d  = lars_pkg::PIX_RESET;
      period_d = '0;
    end
    if (hold_hit) iper_d = period_q;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      integ_q  <= lars_pkg::PIX_RESET;
      period_q <= '0;
      iper_q   <= '0;
    end else begin
      integ_q  <= integ_d;
      period_q <= period_d;
      iper_q   <= iper_d;
    end
  end

  assign integ_period = iper_q;

  //////////////////////////////////////////////////////////////////////////////
  // pixel output and buffered stream toward the converter

  logic [PW-1:0] aout_q, aout_d;
  logic          oe_q, oe_d;
  logic          push;
  logic          ovr_q, ovr_d;

  // value a pixel shows: the last hold, or the one before if it missed it;
  // reads the next-state copies so pixel 1 shows the hold of its own rise
  function automatic logic [PW-1:0] pix_value(input logic [CW-1:0] num);
    logic [CW-1:0] idx;
    idx = num - 1'b1;
    pix_value = stale_d[idx] ? old_d : snap_d;
  endfunction

  // output changes only at a clock rise, so each pixel stands a full period
  always_comb begin
    aout_d = aout_q;
    oe_d   = oe_q;
    if (clk_rise) begin
      oe_d   = (state_d != lars_pkg::LARS_IDLE);
      aout_d = oe_d ? pix_value(cnt_d) : lars_pkg::PIX_RESET;
    end
  end

  // pixels move into the buffer one per clock; a full buffer drops and flags
  assign push = clk_rise && (state_d != lars_pkg::LARS_IDLE);
  always_comb begin
    ovr_d = ovr_q;
    if (start_hit) ovr_d = 1'b0;
    if (push && !fifo_in_ready) ovr_d = 1'b1;  // set wins over the clear
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      aout_q <= lars_pkg::PIX_RESET;
      oe_q   <= 1'b0;
      ovr_q  <= 1'b0;
    end else begin
      aout_q <= aout_d;
      oe_q   <= oe_d;
      ovr_q  <= ovr_d;
    end
  end

  assign pixel_analog_out     = aout_q;
  assign pixel_out_en         = oe_q;
  assign sample_select_switch = cnt_q;
  assign fifo_overrun         = ovr_q;

  lars_fifo #(
    .WIDTH (CW + PW),
    .DEPTH (lars_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   ({cnt_d, pix_value(cnt_d)}),
    .out_valid (stream_valid),
    .out_ready (stream_ready),
    .out_data  ({stream_index, stream_data})
  );

  //////////////////////////////////////////////////////////////////////////////
  // sensor clock speed watch

  logic [lars_pkg::GAP_W-1:0] gap_q, gap_d;
  logic                       fast_q, fast_d, seen_q, seen_d;

  // the first rise after reset has no reference and is not judged
  always_comb begin
    gap_d  = (gap_q == '1) ? gap_q : gap_q + 1'b1;
    fast_d = fast_q;
    seen_d = seen_q;
    if (clk_rise) begin
      if (seen_q && gap_q < MIN_GAP_C) fast_d = 1'b1;
      gap_d  = '0;
      seen_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gap_q  <= '0;
      fast_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      gap_q  <= gap_d;
      fast_q <= fast_d;
      seen_q <= seen_d;
    end
  end

  assign clk_overspeed = fast_q;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  a_start_restart: assert property (@(posedge mclk) disable iff (rst)
    start_hit |=> (state_q == lars_pkg::LARS_SETUP) && (cnt_q == ONE_C) && integrator_reset_switch)
    else $error("start did not restart the sequence");

  a_first_pixel: assert property (@(posedge mclk) disable iff (rst)
    start_hit |=> pixel_out_en && sample_select_switch == ONE_C && samp_q == '0)
    else $error("pixel 1 not presented at start");

  a_pixel_advance: assert property (@(posedge mclk) disable iff (rst)
    clk_rise && !start_s && state_q != lars_pkg::LARS_IDLE && cnt_q < N_C
    |=> sample_select_switch == $past(sample_select_switch) + 1'b1)
    else $error("output did not advance by one pixel");

  a_reset_release: assert property (@(posedge mclk) disable iff (rst)
    clk_rise && !start_s && state_q == lars_pkg::LARS_SETUP && cnt_q == SETUP_C
    |=> !integrator_reset_switch && cnt_q == REL_C ##1 integ_q == $past(light_level))
    else $error("integrators not released at clock 19");

  a_early_resume: assert property (@(posedge mclk) disable iff (rst)
    clk_rise && !start_s && !hold_s && state_q == lars_pkg::LARS_SETUP && cnt_q == SETUP_C
    |=> (&samp_q[lars_pkg::SETUP_CLOCKS-1:0]) && !samp_q[lars_pkg::SETUP_CLOCKS])
    else $error("first pixels did not resume sampling");

  a_output_float: assert property (@(posedge mclk) disable iff (rst)
    clk_rise && !start_s && !hold_s && state_q == lars_pkg::LARS_READ && cnt_q == N_C
    |=> !pixel_out_en && samp_q[N-1] && state_q == lars_pkg::LARS_IDLE)
    else $error("output not floated at clock n+1");

  a_frame_capture: assert property (@(posedge mclk) disable iff (rst)
    hold_hit |=> snap_q == $past(integ_q) && integ_period == $past(period_q))
    else $error("hold did not capture the integrated frame");

  a_pixel_stands: assert property (@(posedge mclk) disable iff (rst)
    !clk_rise |=> $stable(pixel_analog_out) && $stable(pixel_out_en))
    else $error("pixel output changed between clock rises");

  a_clock_speed: assert property (@(posedge mclk) disable iff (rst)
    clk_rise && seen_q && gap_q < MIN_GAP_C |=> clk_overspeed)
    else $error("fast sensor clock not flagged");

endmodule // lars_top

// file: sim/lars_ctrl_model.sv
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// far-side controller: start/hold pulse and sensor clock, clock parked low between frames
module lars_ctrl_model #(
  parameter int N = 24  // pixels per frame
) (
  input  wire logic        mclk,          // system clock
  input  wire logic        rst,           // reset, active high
  input  wire logic        go,            // bench asks for one frame
  input  wire logic [7:0]  half,          // mclk per sensor clock phase
  input  wire logic [15:0] stop_at,       // last rise of the frame, 0 for a full frame
  input  wire logic [15:0] gap,           // idle mclk after the frame
  output logic             sens_clk_pin,  // sensor clock
  output logic             start_pin,     // start pulse
  output logic             hold_pin,      // hold, tied to start
  output logic             busy,          // frame in progress
  output logic [15:0]      rise_cnt       // rises of this frame
);
  // idle levels from time zero
  initial begin
    sens_clk_pin = 1'b0;
    start_pin    = 1'b0;
    busy         = 1'b0;
    rise_cnt     = 16'h0000;
  end

  // hold tied to start, so one exposure ends exactly where the next readout begins
  assign hold_pin = start_pin;

  // one frame: start set up a phase ahead of the first rise, then n+1 rises
  always begin
    @(posedge mclk);
    if (go && !busy && !rst) begin
      busy      <= 1'b1;
      start_pin <= 1'b1;
      repeat (half) @(posedge mclk);
      for (int k = 1; k <= N + 1; k++) begin
        if (stop_at == 16'h0000 || k <= int'(stop_at)) begin
          sens_clk_pin <= 1'b1;
          rise_cnt     <= 16'(k);
          repeat (half) @(posedge mclk);
          start_pin    <= 1'b0;
          sens_clk_pin <= 1'b0;
          repeat (half) @(posedge mclk);
        end
      end
      // charge-transfer wait, scaled far down so that runs stay short
      repeat (gap) @(posedge mclk);
      busy <= 1'b0;
    end
  end
endmodule // lars_ctrl_model

// file: sim/lars_top_bench.sv
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// random light and stalls, restart, buffer overrun and overspeed
module lars_top_bench;
  localparam int NPIX  = 24;                // short chain keeps frames brief
  localparam int CW    = $clog2(NPIX + 2);  // pixel number width
  localparam int LIMIT = 60000;             // mclk ceiling for the whole run

  logic                       mclk, rst, go, stall, sat_next, stream_ready;
  logic                       sens_clk_pin, start_pin, hold_pin, busy, stream_valid;
  logic                       pixel_out_en, integrator_reset_switch, fifo_in_ready, fifo_overrun, clk_overspeed;
  logic [7:0]                 half;
  logic [15:0]                stop_at, gap, rise_cnt;
  logic [lars_pkg::PIX_W-1:0] light_level, pixel_analog_out, stream_data, lvl_used, exp_val, s_exp;
  logic [CW-1:0]              sample_select_switch, stream_index;
  logic [31:0]                integ_period;
  int                         seed, n_errors, cmp_count, cyc, rel_cyc, meas, exp_idx;
  bit                         full_prev, meas_ok, data_ok, s_ok, s_chk;

  ////////////////////////////////////////////////////////////////////////////////
  lars_top #(.N(NPIX)) u_lars_top (
    .mclk(mclk), .rst(rst), .sens_clk_pin(sens_clk_pin), .start_pin(start_pin), .hold_pin(hold_pin),
    .light_level(light_level), .pixel_analog_out(pixel_analog_out), .pixel_out_en(pixel_out_en),
    .integrator_reset_switch(integrator_reset_switch), .sample_select_switch(sample_select_switch),
    .integ_period(integ_period), .stream_valid(stream_valid), .stream_ready(stream_ready),
    .stream_data(stream_data), .stream_index(stream_index), .fifo_in_ready(fifo_in_ready),
    .fifo_overrun(fifo_overrun), .clk_overspeed(clk_overspeed));

  lars_ctrl_model #(.N(NPIX)) u_lars_ctrl_model (
    .mclk(mclk), .rst(rst), .go(go), .half(half), .stop_at(stop_at), .gap(gap),
    .sens_clk_pin(sens_clk_pin), .start_pin(start_pin), .hold_pin(hold_pin), .busy(busy), .rise_cnt(rise_cnt));

  ////////////////////////////////////////////////////////////////////////////////
  // 250 MHz clock
  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  // compare tasks: flags and values
  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("compares=%0d errors=%0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // held pixel value: light summed per mclk of exposure, clipped at full scale
  function automatic logic [lars_pkg::PIX_W-1:0] sat_mul(input logic [lars_pkg::PIX_W-1:0] l, input int m);
    longint p;
    p = longint'(l) * m;
    return (p > longint'(12'hFFF)) ? 12'hFFF : 12'(p);
  endfunction

  // one frame through the controller; returns off the clock edge
  task automatic run_frame(input logic [7:0] h, input logic [15:0] stop, input logic [15:0] g);
    int t;
    half    <= h;
    stop_at <= stop;
    gap     <= g;
    go      <= 1'b1;
    t = 0;
    while (busy !== 1'b1 && t < 100) begin
      @(posedge mclk);
      t++;
    end
    go <= 1'b0;
    t = 0;
    while (busy === 1'b1 && t < 5000) begin
      @(posedge mclk);
      t++;
    end
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // cycle count, hang guard and converter-side ready, stalled on request
  always @(posedge mclk) begin
    cyc          <= cyc + 1;
    stream_ready <= !stall && (($random(seed) & 3) != 0);
    if (cyc == LIMIT) begin
      n_errors++;
      close_out();
    end
  end

  // pin-side monitor: each sensor clock rise is judged once outputs have settled
  always begin
    int k;
    @(posedge sens_clk_pin);
    @(posedge mclk);
    k = int'(rise_cnt);
    if (k == 1) begin
      meas      = cyc - rel_cyc;
      data_ok   = full_prev;
      exp_val   = sat_mul(lvl_used, meas);
      s_ok      = full_prev;
      s_exp     = exp_val;
      s_chk     = !stall;
      exp_idx   = 1;
      full_prev = 1'b0;
    end
    // light changes only during setup, so the exposure sees one level
    if (k == 5) begin
      lvl_used = sat_next ? 12'hFFF : 12'($random(seed) & 7);
      light_level <= lvl_used;
    end
    if (k == lars_pkg::RELEASE_CLOCK) begin
      rel_cyc = cyc + 1;  // first charge lands one mclk after the release is taken
      meas_ok = 1'b1;
    end
    if (k == NPIX + 1) full_prev = 1'b1;
    repeat (5) @(posedge mclk);
    #1;
    if (k == 1 && meas_ok) chk_val(integ_period, 32'(meas));
    if (k == 1) meas_ok = 1'b0;
    if (k <= NPIX) begin
      chk_val(32'(sample_select_switch), 32'(k));
      chk_bit(pixel_out_en, 1'b1);
      chk_bit(integrator_reset_switch, k <= lars_pkg::SETUP_CLOCKS);
      if (data_ok) chk_val(32'(pixel_analog_out), 32'(exp_val));
    end else begin
      chk_val(32'(sample_select_switch), 32'h0);
      chk_bit(pixel_out_en, 1'b0);
      chk_val(32'(pixel_analog_out), 32'h0);
    end
  end

  // converter side: words arrive in pixel order with the held value
  always @(posedge mclk) begin
    if (!rst && s_chk && stream_valid === 1'b1 && stream_ready) begin
      chk_val(32'(stream_index), 32'(exp_idx));
      if (s_ok) chk_val(32'(stream_data), 32'(s_exp));
      exp_idx++;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int t;
    seed = 28;
    rst = 1'b1;
    go = 1'b0;
    stall = 1'b0;
    sat_next = 1'b0;
    half = 8'h14;
    stop_at = 16'h0000;
    gap = 16'h0064;
    light_level = 12'h000;
    stream_ready = 1'b0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk_bit(pixel_out_en, 1'b0);
    chk_val(32'(sample_select_switch), 32'h0);
    chk_bit(fifo_in_ready, 1'b1);
    run_frame(8'h14, 16'h0000, 16'h0064);
    $display("test flush done");
    for (int i = 0; i < 4; i++) begin
      run_frame(8'h14, 16'h0000, 16'(40 + ($random(seed) & 255)));
    end
    $display("test random frames done");
    sat_next = 1'b1;
    run_frame(8'h14, 16'h0000, 16'h0064);
    sat_next = 1'b0;
    run_frame(8'h14, 16'h0000, 16'h0064);
    $display("test saturation done");
    run_frame(8'h14, 16'h000A, 16'h001E);
    run_frame(8'h14, 16'h0000, 16'h0064);
    run_frame(8'h14, 16'h0000, 16'h0064);
    $display("test restart done");
    stall = 1'b1;
    run_frame(8'h14, 16'h0000, 16'h0064);
    chk_bit(fifo_overrun, 1'b1);
    chk_bit(fifo_in_ready, 1'b0);
    stall = 1'b0;
    t = 0;
    while (stream_valid === 1'b1 && t < 100) begin
      @(posedge mclk);
      t++;
    end
    #1;
    chk_bit(fifo_in_ready, 1'b1);
    run_frame(8'h14, 16'h0000, 16'h0064);
    chk_bit(fifo_overrun, 1'b0);
    $display("test overrun done");
    chk_bit(clk_overspeed, 1'b0);
    run_frame(8'h08, 16'h0000, 16'h0064);
    chk_bit(clk_overspeed, 1'b1);
    $display("test overspeed done");
    close_out();
  end
endmodule // lars_top_bench
